//--- hdl/kec_top.sv
// keypad entry checker: keystroke counting, error lamp, displays, transfer
// Operation
// RQ1 - enter before nine keys flags error
// RQ2 - readout needs exactly three keys
// RQ3 - tenth or later key flags error
// RQ4 - digit eight or nine in address errors
// RQ5 - sign key only at fourth position
// RQ6 - fourth key must be a sign
// RQ7 - error lamp holds until clear
// RQ8 - under error, send all ones word
// RQ9 - computer rejects ones in zero positions
// RQ10 - clear blanks address and data displays
// RQ11 - enter blanks address and data displays
// RQ12 - mode select: clear, address, plus, code, enter
// RQ13 - switch parameters entered in non-decimal form
// RQ14 - clear resets counters; digits light windows
// RQ15 - readout shifts address; enter shifts both
// RQ16 - memory read: clear, address, readout
// RQ17 - positions: address, sign, then data
// RQ18 - counter saturates at ten
`timescale 1ns/1ps
module kec_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic key_press,
	input wire logic [3:0] key_code,
	input wire logic octal_entry,
	input wire logic shift_pulse,
	output logic err_lamp_q,
	output logic [11:0] addr_disp_q,
	output logic [19:0] data_disp_q,
	output logic [1:0] sign_disp_q,
	output logic [8:0] disp_lit_q,
	output logic ser_data_q,
	output logic xfer_busy_q
);
	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic press_prev_q;
	logic shift_prev_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {octal_entry, shift_pulse, key_press, key_code};
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			press_prev_q <= 1'b0;
			shift_prev_q <= 1'b0;
		end else begin
			press_prev_q <= sync2_q[4];
			shift_prev_q <= sync2_q[5];
		end
	end

	logic [3:0] code;
	logic key_ev;
	logic shift_tick;
	logic octal_sel;
	assign code = sync2_q[3:0];
	assign key_ev = sync2_q[4] & ~press_prev_q;
	assign shift_tick = sync2_q[5] & ~shift_prev_q;
	assign octal_sel = sync2_q[6];

	logic is_digit;
	logic is_sign;
	logic is_clear;
	logic is_enter;
	logic is_readout;
	assign is_digit = key_ev && (code <= kec_pkg::DIGIT_MAX);
	assign is_sign = key_ev && (code == kec_pkg::KEY_PLUS || code == kec_pkg::KEY_MINUS);
	assign is_clear = key_ev && (code == kec_pkg::KEY_CLEAR);
	assign is_enter = key_ev && (code == kec_pkg::KEY_ENTER);
	assign is_readout = key_ev && (code == kec_pkg::KEY_READOUT);

	// ----------------------------------------
	// keystroke counter
	// ----------------------------------------
	logic [3:0] cnt_q;
	logic [3:0] pos;
	assign pos = cnt_q + 4'h1;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= kec_pkg::CNT_RESET;
		end else if (is_clear) begin
			cnt_q <= kec_pkg::CNT_RESET; // [RQ14]
		end else if ((is_digit || is_sign) && cnt_q < kec_pkg::CNT_SAT) begin
			cnt_q <= pos; // [RQ18]
		end
	end

	// ----------------------------------------
	// error detection
	// ----------------------------------------
	logic err_new;
	always_comb begin
		err_new = 1'b0;
		if (is_enter && cnt_q < kec_pkg::POS_FULL) begin
			err_new = 1'b1; // [RQ1]
		end
		if (is_readout && cnt_q != kec_pkg::POS_ADDR_LAST) begin
			err_new = 1'b1; // [RQ2] [RQ16]
		end
		if ((is_digit || is_sign) && cnt_q >= kec_pkg::POS_FULL) begin
			err_new = 1'b1; // [RQ3]
		end
		// positions 1-3 address, 4 sign, 5-9 data
		if (is_digit && pos <= kec_pkg::POS_ADDR_LAST && code > kec_pkg::OCTAL_MAX) begin
			err_new = 1'b1; // [RQ4] [RQ17]
		end
		if (is_digit && octal_sel && code > kec_pkg::OCTAL_MAX) begin
			err_new = 1'b1; // [RQ13]
		end
		if (is_sign && pos != kec_pkg::POS_SIGN) begin
			err_new = 1'b1; // [RQ5] [RQ12]
		end
		if (is_digit && pos == kec_pkg::POS_SIGN) begin
			err_new = 1'b1; // [RQ6] [RQ17]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			err_lamp_q <= 1'b0;
		end else if (is_clear) begin
			err_lamp_q <= 1'b0; // [RQ7]
		end else if (err_new) begin
			err_lamp_q <= 1'b1; // [RQ7]
		end
	end

	// ----------------------------------------
	// displays
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_disp_q <= 12'h000;
			data_disp_q <= 20'h00000;
			sign_disp_q <= 2'h0;
			disp_lit_q <= 9'h000;
		end else if (is_clear || is_enter) begin
			addr_disp_q <= 12'h000; // [RQ10] [RQ11]
			data_disp_q <= 20'h00000;
			sign_disp_q <= 2'h0;
			disp_lit_q <= 9'h000;
		end else if (is_digit && pos <= kec_pkg::POS_FULL && pos != kec_pkg::POS_SIGN) begin
			// window 8 is the most significant address window
			disp_lit_q[4'h9 - pos] <= 1'b1; // [RQ14]
			if (pos <= kec_pkg::POS_ADDR_LAST) begin
				addr_disp_q <= {addr_disp_q[7:0], code};
			end else begin
				data_disp_q <= {data_disp_q[15:0], code};
			end
		end else if (is_sign && pos == kec_pkg::POS_SIGN) begin
			sign_disp_q <= (code == kec_pkg::KEY_PLUS) ? 2'h1 : 2'h2;
			disp_lit_q[5] <= 1'b1;
		end
	end

	// ----------------------------------------
	// transfer word to the computer
	// ----------------------------------------
	// only the low three bits of an address digit travel; an 8 or 9 has
	// already lit the lamp, so the word is all ones anyway
	logic [kec_pkg::ADDR_W-1:0] addr_word;
	assign addr_word = {addr_disp_q[10:8], addr_disp_q[6:4], addr_disp_q[2:0]};

	logic load_q;
	logic [kec_pkg::WORD_W-1:0] word_q;
	logic [5:0] len_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			load_q <= 1'b0;
			word_q <= '0;
			len_q <= 6'h00;
		end else begin
			load_q <= is_enter || is_readout; // [RQ15]
			if (is_enter) begin
				len_q <= kec_pkg::LEN_ENTER;
				if (err_lamp_q || err_new) begin
					word_q <= '1; // [RQ8] [RQ9]
				end else begin
					word_q <= {addr_word, sign_disp_q[1], data_disp_q};
				end
			end else if (is_readout) begin
				len_q <= kec_pkg::LEN_READOUT;
				if (err_lamp_q || err_new) begin
					word_q <= '1; // [RQ8]
				end else begin
					word_q <= {addr_word, 21'h00000};
				end
			end
		end
	end

	kec_shift #(
		.W(kec_pkg::WORD_W)
	) u_shift (
		.clk(clk),
		.rst_b(rst_b),
		.load(load_q),
		.word(word_q),
		.len(len_q),
		.tick(shift_tick), // [RQ15]
		.ser_data_q(ser_data_q),
		.busy_q(xfer_busy_q)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_enter_early: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
		is_enter && cnt_q < kec_pkg::POS_FULL |=> err_lamp_q)
		else $error("early enter did not light the lamp");
	a_readout_count: assert property (@(posedge clk) disable iff (!rst_b) // [RQ2]
		is_readout && cnt_q != kec_pkg::POS_ADDR_LAST |=> err_lamp_q)
		else $error("readout with wrong count not flagged");
	a_over_length: assert property (@(posedge clk) disable iff (!rst_b) // [RQ3]
		(is_digit || is_sign) && cnt_q >= kec_pkg::POS_FULL |=> err_lamp_q)
		else $error("tenth key not flagged");
	a_addr_octal: assert property (@(posedge clk) disable iff (!rst_b) // [RQ4]
		is_digit && cnt_q < kec_pkg::POS_ADDR_LAST && code > kec_pkg::OCTAL_MAX |=> err_lamp_q)
		else $error("non-octal address digit not flagged");
	a_sign_place: assert property (@(posedge clk) disable iff (!rst_b) // [RQ5]
		is_sign && cnt_q != kec_pkg::POS_ADDR_LAST |=> err_lamp_q)
		else $error("misplaced sign not flagged");
	a_fourth_sign: assert property (@(posedge clk) disable iff (!rst_b) // [RQ6]
		is_digit && cnt_q == kec_pkg::POS_ADDR_LAST |=> err_lamp_q)
		else $error("digit in sign position not flagged");
	a_lamp_sticky: assert property (@(posedge clk) disable iff (!rst_b) // [RQ7]
		err_lamp_q && !is_clear |=> err_lamp_q)
		else $error("error lamp dropped without clear");
	a_inhibit_word: assert property (@(posedge clk) disable iff (!rst_b) // [RQ8]
		err_lamp_q && (is_enter || is_readout) |=> load_q && word_q == '1)
		else $error("error word not all ones");
	a_clear_blank: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
		is_clear |=> disp_lit_q == 9'h000 && !err_lamp_q && cnt_q == kec_pkg::CNT_RESET)
		else $error("clear did not blank and reset");
	a_enter_blank: assert property (@(posedge clk) disable iff (!rst_b) // [RQ11]
		is_enter |=> disp_lit_q == 9'h000 ##1 xfer_busy_q)
		else $error("enter did not blank and start transfer");
	a_cnt_sat: assert property (@(posedge clk) disable iff (!rst_b) // [RQ18]
		cnt_q == kec_pkg::CNT_SAT && !is_clear |=> cnt_q == kec_pkg::CNT_SAT)
		else $error("keystroke counter left saturation");
endmodule // kec_top

//--- common/kec_pkg.sv
// keypad entry checker: shared constants and types
package kec_pkg;
	// ----------------------------------------
	// keystroke codes on the key code pins
	// ----------------------------------------
	localparam logic [3:0] KEY_PLUS = 4'hA;
	localparam logic [3:0] KEY_MINUS = 4'hB;
	localparam logic [3:0] KEY_CLEAR = 4'hC;
	localparam logic [3:0] KEY_ENTER = 4'hD;
	localparam logic [3:0] KEY_READOUT = 4'hE;
	localparam logic [3:0] KEY_HOLD = 4'hF;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] OCTAL_MAX = 4'h7;

	// ----------------------------------------
	// keystroke positions and counter
	// ----------------------------------------
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [3:0] POS_ADDR_LAST = 4'h3;
	localparam logic [3:0] POS_SIGN = 4'h4;
	localparam logic [3:0] POS_FULL = 4'h9;
	localparam logic [3:0] CNT_SAT = 4'hA;

	// ----------------------------------------
	// transfer word layout and lengths
	// ----------------------------------------
	localparam int ADDR_W = 9;
	localparam int DATA_W = 20;
	localparam int WORD_W = 30;
	localparam logic [5:0] LEN_READOUT = 6'h09;
	localparam logic [5:0] LEN_ENTER = 6'h1E;
	localparam int SHIFT_RATE_PPS = 64;

	typedef enum logic [1:0] {
		KEC_SH_IDLE = 2'b01,
		KEC_SH_SHIFT = 2'b10
	} kec_sh_state_t;
endpackage

//--- hdl/kec_shift.sv
// keypad entry checker: serial word shifter toward the computer
`timescale 1ns/1ps
module kec_shift #(
	parameter int W = 30
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [W-1:0] word,
	input wire logic [5:0] len,
	input wire logic tick,
	output logic ser_data_q,
	output logic busy_q
);
	kec_pkg::kec_sh_state_t state_q;
	logic [W-1:0] sr_q;
	logic [5:0] left_q;

	// a new load restarts the shift; the computer sees busy stay high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= kec_pkg::KEC_SH_IDLE;
			sr_q <= '0;
			left_q <= 6'h00;
			ser_data_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (load) begin
			state_q <= kec_pkg::KEC_SH_SHIFT;
			sr_q <= word;
			left_q <= len;
			ser_data_q <= 1'b0;
			busy_q <= 1'b1;
		end else begin
			case (state_q)
				kec_pkg::KEC_SH_IDLE: begin
					busy_q <= 1'b0;
				end
				kec_pkg::KEC_SH_SHIFT: begin
					if (tick) begin
						ser_data_q <= sr_q[W-1];
						sr_q <= {sr_q[W-2:0], 1'b0};
						left_q <= left_q - 6'h01;
						if (left_q == 6'h01) begin
							state_q <= kec_pkg::KEC_SH_IDLE;
							busy_q <= 1'b0;
						end
					end
				end
				default: begin
					state_q <= kec_pkg::KEC_SH_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end
endmodule // kec_shift

//--- tb/kec_computer.sv
// computer side model: shift pulses out, serial word in
`timescale 1ns/1ps
module kec_computer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic busy,
	input wire logic ser,
	output logic shift_pulse,
	output logic [29:0] rx_word,
	output logic [5:0] rx_n,
	output logic rx_err
);
	logic [3:0] ph_q;
	logic busy_q;
	// ----------------------------------------
	// shift control and capture
	// ----------------------------------------
	// a period is finished after busy drops so the last bit is still taken
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_q <= 4'h0;
			busy_q <= 1'b0;
			rx_word <= 30'h0;
			rx_n <= 6'h0;
		end else begin
			busy_q <= busy;
			ph_q <= (busy || ph_q != 4'h0) ? ph_q + 4'h1 : 4'h0;
			if (busy && !busy_q) begin
				rx_word <= 30'h0;
				rx_n <= 6'h0;
			end else if (ph_q == 4'hF) begin
				rx_word <= {rx_word[28:0], ser};
				rx_n <= rx_n + 6'h1;
			end
		end
	end
	// line rests low between words
	assign shift_pulse = ph_q[3];
	// ----------------------------------------
	// data digits above nine mark a bad word
	// ----------------------------------------
	always_comb begin
		rx_err = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (rx_n == 6'h1E && rx_word[i*4+:4] > 4'h9) begin
				rx_err = 1'b1;
			end
		end
	end
endmodule // kec_computer

//--- tb/testbench.sv
// testbench: keystroke scenarios against the entry checker
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic key_press = 1'b0;
	logic [3:0] key_code = 4'h0;
	logic octal_entry = 1'b0;
	logic shift_pulse, err_lamp_q, ser_data_q, xfer_busy_q, rx_err;
	logic [11:0] addr_disp_q;
	logic [19:0] data_disp_q;
	logic [1:0] sign_disp_q;
	logic [8:0] disp_lit_q;
	logic [29:0] rx_word;
	logic [5:0] rx_n;
	int mismatches = 0;
	int n_compared = 0;
	kec_top i_dut (.clk(clk), .rst_b(rst_b), .key_press(key_press), .key_code(key_code),
		.octal_entry(octal_entry), .shift_pulse(shift_pulse), .err_lamp_q(err_lamp_q),
		.addr_disp_q(addr_disp_q), .data_disp_q(data_disp_q), .sign_disp_q(sign_disp_q),
		.disp_lit_q(disp_lit_q), .ser_data_q(ser_data_q), .xfer_busy_q(xfer_busy_q));
	kec_computer i_comp (.clk(clk), .rst_b(rst_b), .busy(xfer_busy_q), .ser(ser_data_q),
		.shift_pulse(shift_pulse), .rx_word(rx_word), .rx_n(rx_n), .rx_err(rx_err));
	initial begin
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// drivers and compares
	// ----------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic cmp_blank();
		cmp({31'h0, |{addr_disp_q, data_disp_q, sign_disp_q, disp_lit_q}}, 32'h0);
	endtask
	// pin held 4 clocks each way, longer than the 2-clock synchroniser
	task automatic press(input logic [3:0] c);
		key_code = c;
		key_press = 1'b1;
		repeat (4) @(posedge clk);
		#1 key_press = 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	function automatic logic [3:0] code_of(input byte ch);
		case (ch)
			"+": code_of = kec_pkg::KEY_PLUS;
			"-": code_of = kec_pkg::KEY_MINUS;
			"C": code_of = kec_pkg::KEY_CLEAR;
			"E": code_of = kec_pkg::KEY_ENTER;
			"R": code_of = kec_pkg::KEY_READOUT;
			"H": code_of = kec_pkg::KEY_HOLD;
			default: code_of = 4'(ch - "0");
		endcase
	endfunction
	task automatic keys(input string s);
		for (int i = 0; i < s.len(); i++) begin
			press(code_of(s[i]));
		end
	endtask
	task automatic wait_xfer();
		int n;
		n = 0;
		while (xfer_busy_q !== 1'b0 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		// a transfer that never ends is a failure, not a quiet skip
		if (n >= 2000) begin
			mismatches++;
		end
		repeat (8) @(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_enter(input string s, input logic [8:0] a, input logic sg, input logic [19:0] d);
		keys(s);
		cmp(err_lamp_q, 1'b0);
		cmp(disp_lit_q, 9'h1FF);
		cmp(addr_disp_q, {1'b0, a[8:6], 1'b0, a[5:3], 1'b0, a[2:0]});
		cmp(sign_disp_q, {sg, ~sg});
		cmp(data_disp_q, d);
		keys("E");
		cmp_blank();
		wait_xfer();
		cmp(rx_n, 6'h1E);
		cmp(rx_word, {a, sg, d});
		cmp(rx_err, 1'b0);
	endtask
	task automatic t_readout();
		keys("C7H05R");
		cmp(err_lamp_q, 1'b0);
		wait_xfer();
		cmp(rx_n, 6'h09);
		cmp(rx_word, 30'h1C5);
	endtask
	task automatic t_err(input string s);
		keys(s);
		cmp(err_lamp_q, 1'b1);
	endtask
	task automatic t_inhibit();
		t_err("C123+4E");
		wait_xfer();
		cmp(rx_word, 30'h3FFFFFFF);
		cmp(rx_err, 1'b1);
		t_err("C12R");
		wait_xfer();
		cmp(rx_word, 30'h1FF);
	endtask
	task automatic t_hold_clear();
		t_err("C1+");
		keys("2345");
		cmp(err_lamp_q, 1'b1);
		// nine keys now, so only the lit lamp forces the all-ones word
		keys("678E");
		wait_xfer();
		cmp(rx_word, 30'h3FFFFFFF);
		cmp(err_lamp_q, 1'b1);
		keys("C");
		cmp(err_lamp_q, 1'b0);
		cmp_blank();
		keys("1");
		cmp(disp_lit_q, 9'h100);
		cmp(addr_disp_q[3:0], 4'h1);
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		@(posedge clk);
		#1;
		t_enter("C123+01234", 9'h053, 1'b0, 20'h01234);
		t_enter("C777-98765", 9'h1FF, 1'b1, 20'h98765);
		t_readout();
		t_inhibit();
		t_err("C123+R");
		t_err("C123+123456");
		t_err("C183");
		t_err("C123+-");
		t_err("C1230");
		t_hold_clear();
		octal_entry = 1'b1;
		t_err("C123+8");
		octal_entry = 1'b0;
		end_sim();
	end
endmodule // testbench
